// [rtl/line_irq_pkg.sv]
// Behaviour
// - alarm pending bits reach pin when enabled
// - six event pending bits gated by enables
// - edge select zero: rising edge sets
// - edge select one: either edge sets
// - live driver failure bit at b2
// - live signal loss bit at b0
// - five bit gain code, saturates high
// - peak mode off: present pointer spacing
// - peak mode on: spread since read
// - writing one clears spacing value
// - pending bits clear on write one
// - pulse sum overflow sets b6
// - transmit fifo slip sets b5
// - receive fifo slip sets b4
// - zero run error sets b2
// - bipolar violation sets b1
// - zero run counter wrap sets b0
// - one register set per link, 0x100 apart
// - counter counts only when enable is 01
`default_nettype none
package line_irq_pkg;
	// register byte offsets within one link's window
	localparam logic [7:0] OFF_ALARM_EN = 8'h33;
	localparam logic [7:0] OFF_EVENT_EN = 8'h34;
	localparam logic [7:0] OFF_EDGE_SEL = 8'h35;
	localparam logic [7:0] OFF_LIVE = 8'h36;
	localparam logic [7:0] OFF_GAIN = 8'h37;
	localparam logic [7:0] OFF_TX_SPACING = 8'h38;
	localparam logic [7:0] OFF_RX_SPACING = 8'h39;
	localparam logic [7:0] OFF_ALARM_PEND = 8'h3A;
	localparam logic [7:0] OFF_EVENT_PEND = 8'h3B;
	localparam logic [7:0] OFF_CTRL = 8'h3E;
	// link stride and link count
	localparam logic [9:0] LINK_STRIDE = 10'h100;
	localparam int LINK_COUNT = 4;
	// bit positions
	localparam int BIT_DRIVER_FAIL = 2;
	localparam int BIT_SIGNAL_ABSENT = 0;
	localparam int BIT_PULSE_SUM = 6;
	localparam int BIT_TX_SLIP = 5;
	localparam int BIT_RX_SLIP = 4;
	localparam int BIT_ZERO_RUN = 2;
	localparam int BIT_BIPOLAR = 1;
	localparam int BIT_COUNTER_WRAP = 0;
	// control register fields (peak modes, count enable)
	localparam int BIT_TX_PEAK = 5;
	localparam int BIT_RX_PEAK = 4;
	localparam int POS_COUNT_EN = 0;
	// masks of implemented bits
	localparam logic [7:0] ALARM_MASK = 8'h05;
	localparam logic [7:0] EVENT_MASK = 8'h77;
	localparam logic [7:0] CTRL_MASK = 8'h33;
	// reset value and codes
	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam logic [4:0] GAIN_CODE_MAX = 5'h15;
	localparam logic [1:0] COUNT_EN_ON = 2'h1;
	// condition inputs from one link's detectors
	typedef struct packed {
		logic driver_fail_live;
		logic signal_absent_live;
		logic pulse_sum_over;
		logic tx_fifo_slip;
		logic rx_fifo_slip;
		logic zero_run_err;
		logic bipolar_viol;
		logic [4:0] equalizer_gain_code;
		logic [6:0] tx_pointer_spacing;
		logic [6:0] rx_pointer_spacing;
	} link_cond_s;
endpackage
`default_nettype wire

// [rtl/line_iface_irq_status.sv]
// Implementation choice: the address-and-strobe port.
`default_nettype none
module line_iface_irq_status #(
	parameter int LINKS = 4
) (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_i,
	// register port
	input wire logic [9:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [7:0] rdata_o,
	// detector conditions per link
	input wire line_irq_pkg::link_cond_s [LINKS-1:0] cond_i,
	// interrupt pin, active high level
	output logic irq_o
);
	import line_irq_pkg::*;

	// overview of one link's register window
	// - alarm enable: gates the driver failure and signal loss pendings
	// - event enable: gates the six event pendings
	// - edge select: picks rising only or both edges for the two alarms
	// - live status: present driver failure and signal loss levels
	// - gain status: present equalizer gain code, saturated at the top band
	// - transmit spacing: pointer distance or its spread, cleared by a read or a nonzero write
	// - receive spacing: same as transmit, for the receive fifo
	// - alarm pending: write one to clear, sticky until then
	// - event pending: write one to clear, sticky until then
	// - control: zero run count enable and the two peak mode bits
	//
	// addressing
	// - the upper two address bits pick the link copy
	// - the lower byte picks the register inside the copy
	// - a read of any other place returns zero
	// - a write to any other place is dropped
	//
	// timing seen from the register port
	// - a write takes effect at the edge after the strobe cycle
	// - read data stand in the cycle after the read strobe only
	// - read data are zero in every other cycle
	// - a condition in cycle n sets its pending bit at edge n+1
	// - the interrupt level follows one edge after the pending bit
	//
	// edge detection on the live levels
	// - each live level is compared with its value one cycle earlier
	// - after reset the earlier value counts as low
	// - so a level already high at reset release gives one rising edge
	//
	// clear against set
	// - a write one clear and a new event in the same cycle keep the bit
	// - this way no event is lost in the clear window of the host
	//
	// spacing registers
	// - a read or a nonzero write restarts the peak window
	// - the shown value is zero in the cycle after a restart
	// - after that it tracks the present distance or the spread
	// - the spread is the highest minus the lowest distance in the window
	//
	// zero run counter
	// - counts detected zero run errors only with the enable code set
	// - the event that rolls it from all ones to zero sets the wrap pending
	// - the counter value itself is not readable here
	//
	// limitations
	// - the condition inputs are taken as synchronous to the clock
	// - event inputs are one cycle pulses; a held level sets every cycle
	// - there is no interrupt latch beyond the pending bits themselves
	// - enables only gate the pin; pendings latch with the enable low too

	// refuse link counts that the two link address bits cannot serve
	if (LINKS < 1 || LINKS > LINK_COUNT) begin : links_check
		$error("LINKS out of range");
	end

	// register state per link
	// alarm enable, implemented bits only
	logic [7:0] alarm_en [LINKS];
	// event enable, implemented bits only
	logic [7:0] event_en [LINKS];
	// edge select for the two alarms
	logic [7:0] edge_sel [LINKS];
	// control: count enable and peak modes
	logic [7:0] ctrl [LINKS];
	// sticky alarm pendings
	logic [7:0] alarm_pend [LINKS];
	// sticky event pendings
	logic [7:0] event_pend [LINKS];
	// shown transmit spacing value
	logic [6:0] tx_val [LINKS];
	// shown receive spacing value
	logic [6:0] rx_val [LINKS];
	// lowest transmit distance of the window
	logic [6:0] tx_lo [LINKS];
	// highest transmit distance of the window
	logic [6:0] tx_hi [LINKS];
	// lowest receive distance of the window
	logic [6:0] rx_lo [LINKS];
	// highest receive distance of the window
	logic [6:0] rx_hi [LINKS];
	// zero run error counter
	logic [15:0] zero_count [LINKS];
	// previous live levels for edge detection
	logic [LINKS-1:0] prev_df;
	logic [LINKS-1:0] prev_los;
	// per-link interrupt terms
	logic [LINKS-1:0] link_irq;

	// link select: the link copy sits one stride above the previous one
	function automatic logic hit(input logic [9:0] a, input int l, input logic [7:0] off);
		hit = (a == 10'(l * int'(LINK_STRIDE) + int'(off)));
	endfunction

	// new edge event on a live bit
	function automatic logic edge_event(input logic cur, input logic old, input logic both);
		if (both) begin
			edge_event = cur ^ old;
		end else begin
			edge_event = cur & ~old;
		end
	endfunction

	// peak-to-peak spread
	function automatic logic [6:0] spread(input logic [6:0] lo, input logic [6:0] hi);
		spread = (hi >= lo) ? 7'(hi - lo) : 7'h00;
	endfunction

	genvar g;
	generate
		for (g = 0; g < LINKS; g++) begin : link
			logic [7:0] alarm_set;
			logic [7:0] event_set;
			logic count_wrap;
			logic tx_read;
			logic rx_read;
			// hardware set sources for the pending registers
			always_comb begin
				alarm_set = RESET_BYTE;
				alarm_set[BIT_DRIVER_FAIL] = edge_event(cond_i[g].driver_fail_live, prev_df[g],
					edge_sel[g][BIT_DRIVER_FAIL]);
				alarm_set[BIT_SIGNAL_ABSENT] = edge_event(cond_i[g].signal_absent_live,
					prev_los[g], edge_sel[g][BIT_SIGNAL_ABSENT]);
				event_set = RESET_BYTE;
				event_set[BIT_PULSE_SUM] = cond_i[g].pulse_sum_over;
				event_set[BIT_TX_SLIP] = cond_i[g].tx_fifo_slip;
				event_set[BIT_RX_SLIP] = cond_i[g].rx_fifo_slip;
				event_set[BIT_ZERO_RUN] = cond_i[g].zero_run_err;
				event_set[BIT_BIPOLAR] = cond_i[g].bipolar_viol;
				event_set[BIT_COUNTER_WRAP] = count_wrap;
			end
			// counter wraps when all ones and another event counts
			assign count_wrap = cond_i[g].zero_run_err && (&zero_count[g])
				&& (ctrl[g][POS_COUNT_EN+1:POS_COUNT_EN] == COUNT_EN_ON);
			assign tx_read = rd_i && hit(addr_i, g, OFF_TX_SPACING);
			assign rx_read = rd_i && hit(addr_i, g, OFF_RX_SPACING);

			// software-written control registers
			always_ff @(posedge ref_clk_i) begin
				if (rst_i) begin
					alarm_en[g] <= RESET_BYTE;
					event_en[g] <= RESET_BYTE;
					edge_sel[g] <= RESET_BYTE;
					ctrl[g] <= RESET_BYTE;
				end else if (wr_i) begin
					if (hit(addr_i, g, OFF_ALARM_EN)) begin
						alarm_en[g] <= wdata_i & ALARM_MASK;
					end else if (hit(addr_i, g, OFF_EVENT_EN)) begin
						event_en[g] <= wdata_i & EVENT_MASK;
					end else if (hit(addr_i, g, OFF_EDGE_SEL)) begin
						edge_sel[g] <= wdata_i & ALARM_MASK;
					end else if (hit(addr_i, g, OFF_CTRL)) begin
						ctrl[g] <= wdata_i & CTRL_MASK;
					end
				end
			end

			// pending bits: write one clears, set wins
			always_ff @(posedge ref_clk_i) begin
				if (rst_i) begin
					alarm_pend[g] <= RESET_BYTE;
					event_pend[g] <= RESET_BYTE;
				end else begin
					if (wr_i && hit(addr_i, g, OFF_ALARM_PEND)) begin
						alarm_pend[g] <= ((alarm_pend[g] & ~wdata_i) | alarm_set) & ALARM_MASK;
					end else begin
						alarm_pend[g] <= (alarm_pend[g] | alarm_set) & ALARM_MASK;
					end
					if (wr_i && hit(addr_i, g, OFF_EVENT_PEND)) begin
						event_pend[g] <= ((event_pend[g] & ~wdata_i) | event_set) & EVENT_MASK;
					end else begin
						event_pend[g] <= (event_pend[g] | event_set) & EVENT_MASK;
					end
				end
			end

			// previous live levels
			always_ff @(posedge ref_clk_i) begin
				if (rst_i) begin
					prev_df[g] <= 1'b0;
					prev_los[g] <= 1'b0;
				end else begin
					prev_df[g] <= cond_i[g].driver_fail_live;
					prev_los[g] <= cond_i[g].signal_absent_live;
				end
			end

			// zero run counter, counts only with enable code
			always_ff @(posedge ref_clk_i) begin
				if (rst_i) begin
					zero_count[g] <= 16'h0000;
				end else if (cond_i[g].zero_run_err
					&& ctrl[g][POS_COUNT_EN+1:POS_COUNT_EN] == COUNT_EN_ON) begin
					zero_count[g] <= zero_count[g] + 16'h0001;
				end
			end

			// transmit spacing: present or peak window
			always_ff @(posedge ref_clk_i) begin
				if (rst_i || tx_read || (wr_i && hit(addr_i, g, OFF_TX_SPACING)
					&& wdata_i != RESET_BYTE)) begin
					tx_lo[g] <= cond_i[g].tx_pointer_spacing;
					tx_hi[g] <= cond_i[g].tx_pointer_spacing;
					tx_val[g] <= 7'h00;
				end else begin
					if (cond_i[g].tx_pointer_spacing < tx_lo[g]) begin
						tx_lo[g] <= cond_i[g].tx_pointer_spacing;
					end
					if (cond_i[g].tx_pointer_spacing > tx_hi[g]) begin
						tx_hi[g] <= cond_i[g].tx_pointer_spacing;
					end
					if (ctrl[g][BIT_TX_PEAK]) begin
						tx_val[g] <= spread(tx_lo[g], tx_hi[g]);
					end else begin
						tx_val[g] <= cond_i[g].tx_pointer_spacing;
					end
				end
			end

			// receive spacing: present or peak window
			always_ff @(posedge ref_clk_i) begin
				if (rst_i || rx_read || (wr_i && hit(addr_i, g, OFF_RX_SPACING)
					&& wdata_i != RESET_BYTE)) begin
					rx_lo[g] <= cond_i[g].rx_pointer_spacing;
					rx_hi[g] <= cond_i[g].rx_pointer_spacing;
					rx_val[g] <= 7'h00;
				end else begin
					if (cond_i[g].rx_pointer_spacing < rx_lo[g]) begin
						rx_lo[g] <= cond_i[g].rx_pointer_spacing;
					end
					if (cond_i[g].rx_pointer_spacing > rx_hi[g]) begin
						rx_hi[g] <= cond_i[g].rx_pointer_spacing;
					end
					if (ctrl[g][BIT_RX_PEAK]) begin
						rx_val[g] <= spread(rx_lo[g], rx_hi[g]);
					end else begin
						rx_val[g] <= cond_i[g].rx_pointer_spacing;
					end
				end
			end

			// enabled pendings of this link
			assign link_irq[g] = |(alarm_pend[g] & alarm_en[g])
				| |(event_pend[g] & event_en[g]);
		end
	endgenerate

	// interrupt level is the OR over links
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			irq_o <= 1'b0;
		end else begin
			irq_o <= |link_irq;
		end
	end

	// read mux, data one cycle after the strobe
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			rdata_o <= RESET_BYTE;
		end else if (rd_i) begin
			rdata_o <= RESET_BYTE;
			for (int l = 0; l < LINKS; l++) begin
				// enable and select registers read back as stored, masked to implemented bits
				if (hit(addr_i, l, OFF_ALARM_EN)) begin
					rdata_o <= alarm_en[l];
				end else if (hit(addr_i, l, OFF_EVENT_EN)) begin
					rdata_o <= event_en[l];
				end else if (hit(addr_i, l, OFF_EDGE_SEL)) begin
					rdata_o <= edge_sel[l];
				// live levels straight from the detectors
				end else if (hit(addr_i, l, OFF_LIVE)) begin
					rdata_o <= {5'h00, cond_i[l].driver_fail_live, 1'b0,
						cond_i[l].signal_absent_live};
				// gain code, top band codes fold onto one value
				end else if (hit(addr_i, l, OFF_GAIN)) begin
					rdata_o <= {3'h0, (cond_i[l].equalizer_gain_code > GAIN_CODE_MAX)
						? GAIN_CODE_MAX : cond_i[l].equalizer_gain_code};
				// spacing values, top bit unused
				end else if (hit(addr_i, l, OFF_TX_SPACING)) begin
					rdata_o <= {1'b0, tx_val[l]};
				end else if (hit(addr_i, l, OFF_RX_SPACING)) begin
					rdata_o <= {1'b0, rx_val[l]};
				// sticky pendings and the control register
				end else if (hit(addr_i, l, OFF_ALARM_PEND)) begin
					rdata_o <= alarm_pend[l];
				end else if (hit(addr_i, l, OFF_EVENT_PEND)) begin
					rdata_o <= event_pend[l];
				end else if (hit(addr_i, l, OFF_CTRL)) begin
					rdata_o <= ctrl[l];
				end
			end
		end else begin
			rdata_o <= RESET_BYTE;
		end
	end
endmodule
`default_nettype wire

// [sim/line_irq_chk.sv]
`default_nettype none
// port-level checks of the status block, link 0 window, reserved bits and unmapped offset 0x30 of every link
module line_irq_chk
	import line_irq_pkg::*;
#(
	parameter int LINKS = 4
) (
	// watched ports
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic [9:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [7:0] rdata_o,
	input wire line_irq_pkg::link_cond_s [LINKS-1:0] cond_i,
	input wire logic irq_o
);
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);
	a_read_idle_zero: assert property (!$past(rd_i) |-> rdata_o == 8'h00) else $error("rdata not zero");
	a_live_bits_read: assert property (rd_i && addr_i == 10'h036 |=> rdata_o == {5'h00,
		$past(cond_i[0].driver_fail_live), 1'b0, $past(cond_i[0].signal_absent_live)})
		else $error("live bits wrong");
	a_gain_code_sat: assert property (rd_i && addr_i == 10'h037 |=> rdata_o ==
		(($past(cond_i[0].equalizer_gain_code) > 5'h15) ? 8'h15 :
		{3'h0, $past(cond_i[0].equalizer_gain_code)})) else $error("gain code wrong");
	a_unmapped_read_zero: assert property (rd_i && addr_i[7:0] == 8'h30 |=> rdata_o == 8'h00)
		else $error("unmapped read not zero");
	a_alarm_rsvd_zero: assert property (rd_i && addr_i[7:0] == OFF_ALARM_PEND |=>
		(rdata_o & ~ALARM_MASK) == 8'h00) else $error("alarm reserved bits set");
	a_event_rsvd_zero: assert property (rd_i && addr_i[7:0] == OFF_EVENT_PEND |=>
		(rdata_o & ~EVENT_MASK) == 8'h00) else $error("event reserved bits set");
	a_ctrl_rsvd_zero: assert property (rd_i && addr_i[7:0] == OFF_CTRL |=>
		(rdata_o & ~CTRL_MASK) == 8'h00) else $error("control reserved bits set");
	a_irq_reset_quiet: assert property ($fell(rst_i) |-> !irq_o ##1 !irq_o)
		else $error("irq after reset");
	a_spacing_clear_now: assert property (wr_i && addr_i == 10'h038 && wdata_i != 8'h00 ##1
		rd_i && addr_i == 10'h038 |=> rdata_o == 8'h00) else $error("spacing not cleared");
endmodule
bind line_iface_irq_status line_irq_chk #(.LINKS(LINKS)) u_line_irq_chk (.ref_clk_i(ref_clk_i),
	.rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
	.rdata_o(rdata_o), .cond_i(cond_i), .irq_o(irq_o));
`default_nettype wire

// [sim/tb_top.sv]
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import line_irq_pkg::*;
	logic ref_clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [9:0] addr_i = 10'h000;
	logic [7:0] wdata_i = 8'h00;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	logic [7:0] rdata_o;
	logic irq_o;
	link_cond_s [3:0] cond_i = '0;
	int err_total = 0;
	int check_count = 0;
	int cyc = 0;
	int epos [5] = '{23, 22, 21, 20, 19}; // event field positions
	int ebit [5] = '{BIT_PULSE_SUM, BIT_TX_SLIP, BIT_RX_SLIP, BIT_ZERO_RUN, BIT_BIPOLAR};
	logic [4:0] gv [4] = '{5'h00, 5'h14, 5'h15, 5'h1F};
	always #50 ref_clk_i = ~ref_clk_i;
	line_iface_irq_status #(.LINKS(4)) u_line_iface_irq_status (.ref_clk_i(ref_clk_i),
		.rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
		.rdata_o(rdata_o), .cond_i(cond_i), .irq_o(irq_o));
	task automatic complete_run();
		$display("checks=%0d errors=%0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	// hang guard
	always @(posedge ref_clk_i) begin
		cyc++;
		if (cyc == 90000) begin
			err_total++;
			complete_run();
		end
	end
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			err_total++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [9:0] a, input logic [7:0] v);
		@(posedge ref_clk_i);
		wr_i <= 1'b1;
		addr_i <= a;
		wdata_i <= v;
		@(posedge ref_clk_i);
		wr_i <= 1'b0;
	endtask
	task automatic rd(input logic [9:0] a, input logic [7:0] exp);
		@(posedge ref_clk_i);
		rd_i <= 1'b1;
		addr_i <= a;
		@(posedge ref_clk_i);
		rd_i <= 1'b0;
		#1 chk(rdata_o, exp);
	endtask
	task automatic setc(input int l, input int p, input logic v);
		@(posedge ref_clk_i);
		cond_i[l][p] <= v;
	endtask
	task automatic pulse(input int l, input int p);
		setc(l, p, 1'b1);
		setc(l, p, 1'b0);
	endtask
	task automatic wait_n(input int n);
		repeat (n) @(posedge ref_clk_i);
		#1;
	endtask
	task automatic chk_irq(input logic v);
		chk({7'h00, irq_o}, {7'h00, v});
	endtask
	initial begin
		repeat (5) @(posedge ref_clk_i);
		rst_i <= 1'b0;
		// reset values, masks, unmapped place
		for (logic [9:0] a = 10'h033; a <= 10'h03B; a++) rd(a, 8'h00);
		rd(10'h03E, 8'h00);
		rd(10'h030, 8'h00);
		wr(10'h033, 8'hFF);
		rd(10'h033, 8'h05);
		wr(10'h034, 8'hFF);
		rd(10'h034, 8'h77);
		wr(10'h035, 8'hFF);
		rd(10'h035, 8'h05);
		wr(10'h035, 8'h00);
		wr(10'h03E, 8'h00);
		rd(10'h134, 8'h00);
		// each event source but the counter wrap: set, gate, clear
		for (int i = 0; i < 5; i++) begin
			pulse(0, epos[i]);
			wait_n(1);
			chk_irq(1'b1);
			rd(10'h03B, 8'h01 << ebit[i]);
			wr(10'h034, 8'h77 ^ (8'h01 << ebit[i]));
			wait_n(2);
			chk_irq(1'b0);
			wr(10'h03B, 8'h01 << ebit[i]);
			wr(10'h034, 8'h77);
			wait_n(2);
			chk_irq(1'b0);
		end
		pulse(1, 19);
		wait_n(1);
		rd(10'h13B, 8'h02);
		rd(10'h03B, 8'h00);
		wr(10'h13B, 8'h02);
		// rising edge only, then write zero and write one
		setc(0, 25, 1'b1);
		wait_n(2);
		chk_irq(1'b1);
		rd(10'h036, 8'h04);
		rd(10'h03A, 8'h04);
		setc(0, 25, 1'b0);
		wr(10'h03A, 8'h00);
		rd(10'h03A, 8'h04);
		wr(10'h03A, 8'h04);
		rd(10'h03A, 8'h00);
		wr(10'h033, 8'h01);
		setc(0, 25, 1'b1);
		wait_n(2);
		chk_irq(1'b0);
		wr(10'h033, 8'h05);
		wait_n(2);
		chk_irq(1'b1);
		setc(0, 25, 1'b0);
		wr(10'h03A, 8'h04);
		// both edges
		wr(10'h035, 8'h05);
		setc(0, 24, 1'b1);
		wait_n(2);
		rd(10'h036, 8'h01);
		wr(10'h03A, 8'h01);
		setc(0, 24, 1'b0);
		wait_n(2);
		rd(10'h03A, 8'h01);
		wr(10'h03A, 8'h01);
		wait_n(2);
		chk_irq(1'b0);
		// set and clear in one cycle
		fork
			wr(10'h03B, 8'h02);
			pulse(0, 19);
		join
		rd(10'h03B, 8'h02);
		wr(10'h03B, 8'h02);
		foreach (gv[i]) begin
			@(posedge ref_clk_i);
			cond_i[0].equalizer_gain_code <= gv[i];
			rd(10'h037, {3'h0, (gv[i] > 5'h15) ? 5'h15 : gv[i]});
		end
		// spacing: present value, clear by write, peak spread
		@(posedge ref_clk_i);
		cond_i[0].tx_pointer_spacing <= 7'h2A;
		cond_i[0].rx_pointer_spacing <= 7'h14;
		wait_n(3);
		rd(10'h038, 8'h2A);
		rd(10'h039, 8'h14);
		wait_n(3);
		@(posedge ref_clk_i);
		wr_i <= 1'b1;
		addr_i <= 10'h038;
		wdata_i <= 8'h7F;
		@(posedge ref_clk_i);
		wr_i <= 1'b0;
		rd_i <= 1'b1;
		@(posedge ref_clk_i);
		rd_i <= 1'b0;
		#1 chk(rdata_o, 8'h00);
		wr(10'h03E, 8'h10);
		wr(10'h039, 8'h7F);
		wait_n(3);
		@(posedge ref_clk_i);
		cond_i[0].rx_pointer_spacing <= 7'h0C;
		wait_n(3);
		@(posedge ref_clk_i);
		cond_i[0].rx_pointer_spacing <= 7'h10;
		wait_n(3);
		rd(10'h039, 8'h08);
		// counter: 65535 counted events, one uncounted, then the wrap
		wr(10'h03E, 8'h01);
		@(posedge ref_clk_i);
		cond_i[0].zero_run_err <= 1'b1;
		repeat (65535) @(posedge ref_clk_i);
		cond_i[0].zero_run_err <= 1'b0;
		wait_n(2);
		rd(10'h03B, 8'h04);
		wr(10'h03E, 8'h02);
		pulse(0, 20);
		wait_n(1);
		rd(10'h03B, 8'h04);
		wr(10'h03E, 8'h01);
		pulse(0, 20);
		wait_n(1);
		rd(10'h03B, 8'h05);
		complete_run();
	end
endmodule
`default_nettype wire
